// *** include/sht_map.svh ***
/*
  Constants for the standby controller: register addresses, reset values,
  wait-select codes and stabilization thresholds.
  Assumes inclusion by the core module only.
*/
`ifndef SHT_MAP_SVH
`define SHT_MAP_SVH

`define SHT_ADDR_STATUS    16'hffa3
`define SHT_ADDR_WAIT_SEL  16'hffa4
`define SHT_STATUS_RESET   8'h00
`define SHT_WAIT_SEL_RESET 3'h5
`define SHT_SEL_2E11       3'h1
`define SHT_SEL_2E13       3'h2
`define SHT_SEL_2E14       3'h3
`define SHT_SEL_2E15       3'h4
`define SHT_SEL_2E16       3'h5
`define SHT_THR_2E11       17'h00800
`define SHT_THR_2E13       17'h02000
`define SHT_THR_2E14       17'h04000
`define SHT_THR_2E15       17'h08000
`define SHT_THR_2E16       17'h10000
`define SHT_VEC_WAIT       4'h8
`define SHT_NEXT_WAIT      4'h2

`endif

// *** include/sht_pkg.sv ***
/*
  Types for the standby controller.
  Assumes sht_map.svh is on the include path.
*/
package sht_pkg;

  typedef enum logic [1:0] {
    SHT_RUN,
    SHT_HALT,
    SHT_WAKE
  } sht_state_e;

  // Interrupt-controller and status-word view of one wake source
  typedef struct packed {
    logic irq_request;
    logic irq_mask_flag;
    logic irq_priority_flag;
    logic global_irq_enable_flag;
    logic in_service_priority_flag;
    logic nmi_request;
  } sht_wake_s;

  // Register access from the CPU memory bus
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic        bit_acc;
    logic [7:0]  wdata;
  } sht_mem_s;

endpackage

// *** core/sht_standby_ctrl.sv ***
/*
  Standby controller: HALT-mode CPU clock gating and release, main
  oscillator stabilization counter with status and wait-select registers.
  Assumes one 10 MHz clock, the CPU memory bus on the same clock, and the
  main-oscillator clock seen as an asynchronous level that is sampled.
*/
// Notes on behaviour
// - Status clears on reset release, STOP execution and oscillator-stop write.
// - Status bits set in order at 2^11..2^16 counts and stay set.
// - Status is read-only, bit or byte readable, upper three bits zero.
// - Select codes 1..5 give 2^11,2^13,2^14,2^15,2^16 waits; others prohibited.
// - Wait select resets to 05h, byte writes only, upper bits read zero.
// - Selected wait applies on STOP release only when crystal clocks the CPU.
// - Counter stops at selected wait, so status stops at that threshold.
// - Wait counting starts only once the oscillator actually runs.
// - HALT instruction enters HALT whatever clock drives the CPU.
// - HALT stops CPU clock, oscillators keep running, port latches hold.
// - Unmasked interrupt releases HALT, servicing if enabled (and in-service set when priority flag set), else next instruction.
// - Release resumes after 8 clocks with servicing, 2 clocks without.
// - Non-maskable request releases HALT with servicing regardless of enable.
// - External reset releases HALT and runs the normal reset sequence.
// - Masked holds HALT; priority, enable and in-service choose servicing.
`timescale 1ns/1ns
`default_nettype none
`include "sht_map.svh"

module sht_standby_ctrl
  import sht_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire sht_mem_s   mem,
  output logic [7:0]      rdata,
  output logic            rd_hit,
  input  wire logic       halt_exec,
  input  wire logic       stop_exec,
  input  wire logic       stop_release,
  input  wire logic       main_osc_stop_bit_wr,
  input  wire logic       cpu_on_main_crystal,
  input  wire logic       main_crystal_osc,
  input  wire sht_wake_s  wake,
  output logic            cpu_clk_en,
  output logic            port_latch_hold,
  output logic            resume_pulse,
  output logic            resume_vectored,
  output logic            stop_wait_busy
);

  sht_state_e  state_r;
  logic        osc_s1_r;
  logic        osc_s2_r;
  logic        osc_s3_r;
  logic [16:0] osc_count_r;
  logic [4:0]  osc_stab_status_r;
  logic [2:0]  osc_stab_wait_select_r;
  logic        counting_r;
  logic        stop_wait_r;
  logic [3:0]  wake_cnt_r;
  logic        vec_r;
  logic [16:0] wait_limit;
  logic        osc_edge;
  logic        wake_any;
  logic        wake_vec;
  logic        stat_clear;

  // Crystal clock passes two flops before use; third flop only for edge finding
  always_ff @(posedge sys_clk) begin
    osc_s1_r <= main_crystal_osc;
    osc_s2_r <= osc_s1_r;
    osc_s3_r <= osc_s2_r;
  end

  assign osc_edge   = osc_s2_r & ~osc_s3_r;
  assign stat_clear = stop_exec | main_osc_stop_bit_wr;

  // Decode of the select field into a cycle limit
  always_comb begin
    case (osc_stab_wait_select_r)
      `SHT_SEL_2E11: wait_limit = `SHT_THR_2E11;
      `SHT_SEL_2E13: wait_limit = `SHT_THR_2E13;
      `SHT_SEL_2E14: wait_limit = `SHT_THR_2E14;
      `SHT_SEL_2E15: wait_limit = `SHT_THR_2E15;
      default:       wait_limit = `SHT_THR_2E16;
    endcase
  end

  // Wait-select register, byte writes only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      osc_stab_wait_select_r <= `SHT_WAIT_SEL_RESET;
    end else if (mem.wr && !mem.bit_acc && mem.addr == `SHT_ADDR_WAIT_SEL) begin
      osc_stab_wait_select_r <= mem.wdata[2:0];
    end
  end

  // Counter runs on crystal edges from a clear until the selected limit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      osc_count_r <= 17'h00000;
      counting_r  <= 1'b1;
    end else if (stat_clear) begin
      osc_count_r <= 17'h00000;
      counting_r  <= 1'b1;
    end else if (counting_r && osc_edge) begin
      osc_count_r <= osc_count_r + 17'h00001;
      if (osc_count_r + 17'h00001 >= wait_limit) begin
        counting_r <= 1'b0;
      end
    end
  end

  // Status flags set in order from the lowest threshold and stay set
  always_ff @(posedge sys_clk) begin
    if (!resetn || stat_clear) begin
      osc_stab_status_r <= 5'(`SHT_STATUS_RESET);
    end else begin
      if (osc_count_r >= `SHT_THR_2E11) osc_stab_status_r[4] <= 1'b1;
      if (osc_count_r >= `SHT_THR_2E13) osc_stab_status_r[3] <= 1'b1;
      if (osc_count_r >= `SHT_THR_2E14) osc_stab_status_r[2] <= 1'b1;
      if (osc_count_r >= `SHT_THR_2E15) osc_stab_status_r[1] <= 1'b1;
      if (osc_count_r >= `SHT_THR_2E16) osc_stab_status_r[0] <= 1'b1;
    end
  end

  // STOP release wait, only when the crystal is the CPU clock
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stop_wait_r <= 1'b0;
    end else if (stop_release && cpu_on_main_crystal) begin
      stop_wait_r <= 1'b1;
    end else if (stop_wait_r && !counting_r) begin
      stop_wait_r <= 1'b0;
    end
  end

  assign stop_wait_busy = stop_wait_r;

  // Register read port; bit accesses read the same byte
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata  <= 8'h00;
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= mem.rd && (mem.addr == `SHT_ADDR_STATUS || mem.addr == `SHT_ADDR_WAIT_SEL);
      if (mem.rd && mem.addr == `SHT_ADDR_STATUS) begin
        rdata <= {3'h0, osc_stab_status_r};
      end else if (mem.rd && mem.addr == `SHT_ADDR_WAIT_SEL) begin
        rdata <= {5'h00, osc_stab_wait_select_r};
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // Wake decision from interrupt controller and status word
  always_comb begin
    wake_any = wake.nmi_request | (wake.irq_request & ~wake.irq_mask_flag);
    if (wake.nmi_request) begin
      wake_vec = 1'b1;
    end else if (!wake.irq_priority_flag) begin
      wake_vec = wake.global_irq_enable_flag;
    end else begin
      wake_vec = wake.global_irq_enable_flag & wake.in_service_priority_flag;
    end
  end

  // HALT state machine; reset returns to run
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r    <= SHT_RUN;
      wake_cnt_r <= 4'h0;
      vec_r      <= 1'b0;
    end else begin
      case (state_r)
        SHT_RUN: begin
          if (halt_exec) begin
            state_r <= SHT_HALT;
          end
        end
        SHT_HALT: begin
          if (wake_any) begin
            state_r    <= SHT_WAKE;
            vec_r      <= wake_vec;
            wake_cnt_r <= wake_vec ? `SHT_VEC_WAIT : `SHT_NEXT_WAIT;
          end
        end
        SHT_WAKE: begin
          wake_cnt_r <= wake_cnt_r - 4'h1;
          if (wake_cnt_r == 4'h1) begin
            state_r <= SHT_RUN;
          end
        end
        default: state_r <= SHT_RUN;
      endcase
    end
  end

  // CPU clock gated while halted; ports hold their latches
  assign cpu_clk_en      = (state_r == SHT_RUN);
  assign port_latch_hold = (state_r != SHT_RUN);
  assign resume_pulse    = (state_r == SHT_WAKE) && (wake_cnt_r == 4'h1);
  assign resume_vectored = resume_pulse && vec_r;

endmodule
`default_nettype wire

// *** tb/sht_standby_ctrl_properties.sv ***
/* Port checker for the standby controller.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module sht_checker
  import sht_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire sht_mem_s   mem,
  input wire logic [7:0] rdata,
  input wire logic       rd_hit,
  input wire logic       halt_exec,
  input wire logic       cpu_on_main_crystal,
  input wire sht_wake_s  wake,
  input wire logic       cpu_clk_en,
  input wire logic       port_latch_hold,
  input wire logic       resume_pulse,
  input wire logic       resume_vectored,
  input wire logic       stop_wait_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // HALT gating, release timing, register answers and the crystal condition of the STOP wait
  halt_gate_a: assert property (halt_exec && cpu_clk_en |=> !cpu_clk_en)
    else $error("halt left clock on");
  latch_hold_a: assert property (!cpu_clk_en |-> port_latch_hold)
    else $error("latches not held");
  resume_run_a: assert property (resume_pulse |=> cpu_clk_en)
    else $error("clock not back");
  vec_wait_a: assert property (resume_vectored |-> resume_pulse && !$past(cpu_clk_en, 8))
    else $error("vectored wait wrong");
  next_wait_a: assert property (resume_pulse && !resume_vectored |-> !$past(cpu_clk_en, 2))
    else $error("next wait wrong");
  nmi_vec_a: assert property (resume_pulse && wake.nmi_request |-> resume_vectored)
    else $error("nmi not vectored");
  status_top_a: assert property (rd_hit && $past(mem.addr) == 16'hffa3 |-> rdata[7:5] == 3'h0)
    else $error("status top bits set");
  sel_top_a: assert property (rd_hit && $past(mem.addr) == 16'hffa4 |-> rdata[7:3] == 5'h00)
    else $error("select top bits set");
  busy_xtal_a: assert property ($rose(stop_wait_busy) |-> cpu_on_main_crystal)
    else $error("wait without crystal");
  cover property (resume_vectored);
  cover property (resume_pulse && !resume_vectored);
  cover property ($fell(stop_wait_busy));
endmodule
bind sht_standby_ctrl sht_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .mem(mem),
  .rdata(rdata), .rd_hit(rd_hit), .halt_exec(halt_exec), .cpu_on_main_crystal(cpu_on_main_crystal),
  .wake(wake), .cpu_clk_en(cpu_clk_en), .port_latch_hold(port_latch_hold),
  .resume_pulse(resume_pulse), .resume_vectored(resume_vectored), .stop_wait_busy(stop_wait_busy));
`default_nettype wire

// *** tb/sht_cpu_model.sv ***
/* Model of the CPU core and interrupt controller feeding wake flags.
   Assumes the bench pulses go at a falling edge with new flags. */
`timescale 1ns/1ns
`default_nettype none
module sht_cpu_model
  import sht_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      go,
  input  wire sht_wake_s cfg,
  input  wire logic      resume_pulse,
  output sht_wake_s      wake
);
  initial wake = '0;
  // Request stays pending until the CPU resumes; flags move just after a rising edge
  always @(posedge sys_clk) begin
    wake <= go ? cfg : (resume_pulse ? '0 : wake);
  end
endmodule
`default_nettype wire

// *** tb/tb_sht_standby_ctrl.sv ***
/* Testbench for the standby controller: HALT release, registers, wait.
   Assumes the bound checker and the CPU model beside the design. */
`timescale 1ns/1ns
`default_nettype none
module tb_sht_standby_ctrl;
  import sht_pkg::*;
  logic       sys_clk, resetn, halt_exec, stop_exec, stop_rel, osc_wr, on_xtal, xtal, xtal_on, go;
  logic [7:0] rdata;
  logic       rd_hit, clk_en, hold, res_p, res_v, busy;
  sht_mem_s   mem;
  sht_wake_s  cfg, wake;
  int         err_count, cmp_count, n;
  sht_wake_s  cs[7] = '{6'h20, 6'h24, 6'h2a, 6'h2c, 6'h2e, 6'h36, 6'h01};
  int         ws[7] = '{3, 9, 3, 3, 9, 20, 9};
  sht_standby_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .mem(mem), .rdata(rdata),
    .rd_hit(rd_hit), .halt_exec(halt_exec), .stop_exec(stop_exec), .stop_release(stop_rel),
    .main_osc_stop_bit_wr(osc_wr), .cpu_on_main_crystal(on_xtal), .main_crystal_osc(xtal),
    .wake(wake), .cpu_clk_en(clk_en), .port_latch_hold(hold), .resume_pulse(res_p),
    .resume_vectored(res_v), .stop_wait_busy(busy));
  sht_cpu_model partner (.sys_clk(sys_clk), .go(go), .cfg(cfg), .resume_pulse(res_p), .wake(wake));
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Crystal stands still unless enabled
  initial begin
    xtal = 0;
    forever #130 xtal = xtal_on ? ~xtal : 1'b0;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; a read compares data against d and hit against the register addresses
  task automatic bus(input logic [15:0] a, input logic w, input logic b, input logic [7:0] d);
    mem = '{a, !w, w, b, d};
    @(negedge sys_clk) mem = '0;
    if (!w) begin
      chk(rdata, d);
      chk({7'h0, rd_hit}, {7'h0, a inside {16'hffa3, 16'hffa4}});
    end
    @(negedge sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge sys_clk) s = 0;
  endtask
  task automatic t_halt(input sht_wake_s c, input int w);
    pulse(halt_exec);
    chk({7'h0, clk_en}, 8'h00);
    chk({7'h0, hold}, 8'h01);
    cfg = c;
    go = 1;
    @(negedge sys_clk) go = 0;
    n = 1;
    while (!res_p && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(8'(n), 8'(w));
    chk({7'h0, res_v}, {7'h0, w == 9});
    @(negedge sys_clk);
  endtask
  task automatic t_rst;
    pulse(halt_exec);
    resetn = 0;
    @(negedge sys_clk) resetn = 1;
    chk({7'h0, clk_en}, 8'h01);
  endtask
  task automatic t_regs;
    bus(16'hffa3, 0, 0, 8'h00);
    bus(16'hffa4, 0, 0, 8'h05);
    bus(16'hffa3, 1, 0, 8'hff);
    bus(16'hffa3, 0, 0, 8'h00);
    bus(16'hffa4, 1, 1, 8'h01);
    bus(16'hffa4, 0, 0, 8'h05);
    bus(16'hffa4, 1, 0, 8'hfa);
    bus(16'hffa4, 0, 0, 8'h02);
    bus(16'hffa5, 0, 0, 8'h00);
  endtask
  task automatic t_stab;
    pulse(stop_exec);
    pulse(stop_rel);
    chk({7'h0, busy}, 8'h00);
    on_xtal = 1;
    pulse(stop_exec);
    pulse(stop_rel);
    repeat (50) @(negedge sys_clk);
    chk({7'h0, busy}, 8'h01);
    xtal_on = 1;
    repeat (6000) @(negedge sys_clk);
    bus(16'hffa3, 0, 0, 8'h10);
    n = 0;
    while (busy && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h0, busy}, 8'h00);
    repeat (100) @(negedge sys_clk);
    bus(16'hffa3, 0, 0, 8'h18);
    pulse(osc_wr);
    bus(16'hffa3, 0, 0, 8'h00);
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #4000000;
    err_count++;
    conclude();
  end
  initial begin
    {resetn, halt_exec, stop_exec, stop_rel, osc_wr, on_xtal, xtal_on, go} = '0;
    mem = '0;
    cfg = '0;
    repeat (3) @(negedge sys_clk);
    resetn = 1;
    for (int i = 0; i < 7; i++) t_halt(cs[i], ws[i]);
    t_rst();
    t_regs();
    t_stab();
    conclude();
  end
endmodule
`default_nettype wire
